/* verilog/acc_top.sv */
`timescale 1ns/1ps
module acc_top
  import acc_pkg::*;
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  // register port
  input wire logic [ACC_ADDR_W-1:0] i_addr,
  input wire logic [ACC_DATA_W-1:0] i_wr_data,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [ACC_DATA_W-1:0] o_rd_data,
  // power state from the device clock control
  input wire logic i_sleep,
  input wire logic i_idle,
  // raw comparator results from the analog cores
  input wire logic [ACC_NUM_CMP-1:0] i_cmp_raw,
  // analog steering per comparator
  output acc_ana_t [ACC_NUM_CMP-1:0] o_analog,
  // pad control for the sixteen source pins
  output logic [ACC_NUM_PIN-1:0] o_pad_dig_in_off,
  // consumers of the comparator result
  output logic [ACC_NUM_CMP-1:0] o_pwm_cmp,
  output logic [ACC_NUM_CMP-1:0] o_adc_trig,
  output logic [ACC_NUM_CMP-1:0] o_irq_pulse,
  output logic [ACC_NUM_CMP-1:0] o_wake_req
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------

  // which comparator an address names; the top address bit is not decoded,
  // so the upper eight addresses mirror the lower eight
  function automatic logic [1:0] cmp_index(input logic [ACC_ADDR_W-1:0] a);
    cmp_index = a[ACC_SEL_W:1];
  endfunction

  // true when the address selects the reference level register
  function automatic logic is_ref_reg(input logic [ACC_ADDR_W-1:0] a);
    is_ref_reg = a[0];
  endfunction

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  acc_bus_t bus;                                // bundled request
  acc_cfg_t cfg [ACC_NUM_CMP];                  // control registers
  logic [ACC_CODE_W-1:0] ref_code [ACC_NUM_CMP];  // reference level registers
  logic [ACC_NUM_CMP-1:0] sync_a;               // first synchroniser stage
  logic [ACC_NUM_CMP-1:0] sync_b;               // second synchroniser stage
  logic [ACC_NUM_CMP-1:0] filt;                 // filtered, polarity applied
  logic [ACC_NUM_CMP-1:0] filt_d;               // filtered, one cycle later
  logic [1:0] filt_cnt [ACC_NUM_CMP];           // stability counters
  logic [ACC_NUM_CMP-1:0] active;               // comparator running
  logic [ACC_NUM_CMP-1:0] low_power;            // sleep/idle path in use
  logic [ACC_NUM_CMP-1:0] pulse;                // one-cycle event pulses
  logic [ACC_NUM_CMP-1:0] sidl_bits;            // idle stop bits gathered
  logic group_idle_stop;                        // whole group halted
  logic [ACC_DATA_W-1:0] next_rd_data;          // read mux result

  // ----------------------------------------------------------------
  // bus bundling
  // ----------------------------------------------------------------
  assign bus = '{wr: i_wr, rd: i_rd, addr: i_addr, wdata: i_wr_data};

  // ----------------------------------------------------------------
  // group idle stop
  // ----------------------------------------------------------------

  // gather idle stop bits of all comparators
  always_comb
  begin
    for (int k = 0; k < ACC_NUM_CMP; k++)
    begin
      sidl_bits[k] = cfg[k].idle_stop_all;
    end
  end

  // one shared stop keeps clock control simple: any set bit halts the group
  // any bit stops group
  assign group_idle_stop = i_idle && (|sidl_bits);

  // ----------------------------------------------------------------
  // per-comparator logic
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < ACC_NUM_CMP; g++)
    begin : gen_cmp
      logic pol_now;    // synchronised result after polarity
      logic pol_async;  // unsynchronised result after polarity

      // control register write
      // reset to zero
      always_ff @(posedge i_clk_sys or negedge i_rst_b)
      begin
        if (!i_rst_b)
        begin
          // every control field starts cleared, comparator off
          cfg[g] <= acc_cfg_t'(ACC_RST_CTRL[$bits(acc_cfg_t)-1:0]);
        end
        else if (bus.wr && !is_ref_reg(bus.addr) && cmp_index(bus.addr) == 2'(g))
        begin
          cfg[g].module_on <= bus.wdata[ACC_B_MODULE_ON];
          cfg[g].idle_stop_all <= bus.wdata[ACC_B_IDLE_STOP];
          cfg[g].reference_pin_drive_enable <= bus.wdata[ACC_B_PIN_DRIVE];
          cfg[g].input_source_select <= bus.wdata[ACC_B_SEL_HI:ACC_B_SEL_LO];
          cfg[g].external_reference_select <= bus.wdata[ACC_B_EXT_REF];
          cfg[g].output_invert <= bus.wdata[ACC_B_INVERT];
          cfg[g].range_high <= bus.wdata[ACC_B_RANGE];
        end
      end

      // reference level register write
      // ten-bit code per comparator
      always_ff @(posedge i_clk_sys or negedge i_rst_b)
      begin
        if (!i_rst_b)
        begin
          ref_code[g] <= ACC_RST_CODE;
        end
        else if (bus.wr && is_ref_reg(bus.addr) && cmp_index(bus.addr) == 2'(g))
        begin
          ref_code[g] <= bus.wdata[ACC_CODE_W-1:0];
        end
      end

      // running state and low-power path selection
      // off disables all
      assign active[g] = cfg[g].module_on && !group_idle_stop;
      assign low_power[g] = i_sleep || i_idle;

      // analog steering
      always_comb
      begin
        o_analog[g].cmp_power = active[g];
        o_analog[g].dac_power = active[g];
        if (cfg[g].external_reference_select)
        begin
          o_analog[g].dac_range = ACC_RNG_EXTERNAL;
        end
        else if (cfg[g].range_high)
        begin
          o_analog[g].dac_range = ACC_RNG_HALF_SUPPLY;
        end
        else
        begin
          o_analog[g].dac_range = ACC_RNG_INTERNAL;
        end
        o_analog[g].plus_select = cfg[g].input_source_select;
        o_analog[g].reference_code = ref_code[g];
        o_analog[g].pin_drive = cfg[g].reference_pin_drive_enable && active[g];
      end

      // pad digital buffer control, four pins per comparator
      // keeps analog levels out of the digital input stage; the adc still sees the pin
      // buffer off when selected
      for (genvar p = 0; p < ACC_NUM_SRC; p++)
      begin : gen_pad
        assign o_pad_dig_in_off[g*ACC_NUM_SRC+p] =
          cfg[g].module_on && (cfg[g].input_source_select == 2'(p));
      end

      // two-stage synchroniser of the raw result
      // the raw result is asynchronous to the clock; two stages keep
      // metastable values away from the filter and the pulse logic
      // synchronise before filter
      always_ff @(posedge i_clk_sys or negedge i_rst_b)
      begin
        if (!i_rst_b)
        begin
          sync_a[g] <= 1'b0;
          sync_b[g] <= 1'b0;
        end
        else
        begin
          sync_a[g] <= i_cmp_raw[g];
          sync_b[g] <= sync_a[g];
        end
      end

      // polarity selection
      // invert when set
      assign pol_now = (sync_b[g] ^ cfg[g].output_invert) && active[g];
      assign pol_async = (i_cmp_raw[g] ^ cfg[g].output_invert) && active[g];

      // glitch filter: output follows only after a stable two cycles
      // a change must be seen on two successive edges; a one-cycle spike
      // clears the count, so it never reaches the output
      // reject short transients
      always_ff @(posedge i_clk_sys or negedge i_rst_b)
      begin
        if (!i_rst_b)
        begin
          filt[g] <= 1'b0;
          filt_cnt[g] <= 2'h0;
        end
        else if (pol_now == filt[g])
        begin
          // no change pending
          filt_cnt[g] <= 2'h0;
        end
        else if (filt_cnt[g] == ACC_FILT_MAX)
        begin
          // change held long enough
          filt[g] <= pol_now;
          filt_cnt[g] <= 2'h0;
        end
        else
        begin
          // change seen, keep counting
          filt_cnt[g] <= filt_cnt[g] + 2'h1;
        end
      end

      // edge memory for the pulse generator
      always_ff @(posedge i_clk_sys or negedge i_rst_b)
      begin
        if (!i_rst_b)
        begin
          filt_d[g] <= 1'b0;
        end
        else
        begin
          filt_d[g] <= filt[g];
        end
      end

      // one-cycle pulse on each rising edge of the filtered result
      // one-cycle event pulse
      assign pulse[g] = filt[g] && !filt_d[g];

      // event outputs registered so they start clean from reset
      // one result, many users
      always_ff @(posedge i_clk_sys or negedge i_rst_b)
      begin
        if (!i_rst_b)
        begin
          o_adc_trig[g] <= 1'b0;
          o_irq_pulse[g] <= 1'b0;
        end
        else
        begin
          o_adc_trig[g] <= pulse[g];
          o_irq_pulse[g] <= pulse[g];
        end
      end

      // filtered level to the pwm current limit, period and fault logic
      assign o_pwm_cmp[g] = filt[g];

      // asynchronous wake path, filter bypassed in sleep or idle
      // reads the raw result on purpose: with the clock stopped in sleep
      // no flip-flop may stand in this path
      // bypass filter asynchronously
      assign o_wake_req[g] = low_power[g] && pol_async;
    end
  endgenerate

  // ----------------------------------------------------------------
  // register read
  // ----------------------------------------------------------------

  // read mux; the level register reads back code in the low bits
  // reserved and unused bits read zero
  always_comb
  begin
    next_rd_data = ACC_ZERO;
    if (is_ref_reg(bus.addr))
    begin
      next_rd_data[ACC_CODE_W-1:0] = ref_code[cmp_index(bus.addr)];
    end
    else
    begin
      next_rd_data[ACC_B_MODULE_ON] = cfg[cmp_index(bus.addr)].module_on;
      next_rd_data[ACC_B_IDLE_STOP] = cfg[cmp_index(bus.addr)].idle_stop_all;
      next_rd_data[ACC_B_PIN_DRIVE] =
        cfg[cmp_index(bus.addr)].reference_pin_drive_enable;
      next_rd_data[ACC_B_SEL_HI:ACC_B_SEL_LO] =
        cfg[cmp_index(bus.addr)].input_source_select;
      next_rd_data[ACC_B_EXT_REF] =
        cfg[cmp_index(bus.addr)].external_reference_select;
      next_rd_data[ACC_B_STATE] = filt[cmp_index(bus.addr)];
      next_rd_data[ACC_B_INVERT] = cfg[cmp_index(bus.addr)].output_invert;
      next_rd_data[ACC_B_RANGE] = cfg[cmp_index(bus.addr)].range_high;
    end
  end

  // read data stands only in the cycle after the strobe
  // returning to zero between reads keeps stale values off the bus
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_rd_data <= ACC_ZERO;
    end
    else if (bus.rd)
    begin
      o_rd_data <= next_rd_data;
    end
    else
    begin
      o_rd_data <= ACC_ZERO;
    end
  end

endmodule

/* verilog/acc_pkg.sv */
// ----------------------------------------------------------------
// shared constants and types of the comparator control block
// ----------------------------------------------------------------
package acc_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int ACC_NUM_CMP = 4;           // comparators in the group
  localparam int ACC_NUM_SRC = 4;           // selectable sources per comparator
  localparam int ACC_NUM_PIN = 16;          // source pins across the group
  localparam int ACC_DATA_W = 16;           // register width
  localparam int ACC_ADDR_W = 4;            // register address width
  localparam int ACC_CODE_W = 10;           // reference dac code width
  localparam int ACC_SEL_W = 2;             // source select width

  // ----------------------------------------------------------------
  // register map: control at 2*n, reference level at 2*n+1
  // ----------------------------------------------------------------
  localparam logic [ACC_ADDR_W-1:0] ACC_OFS_CTRL0 = 4'h0;
  localparam logic [ACC_ADDR_W-1:0] ACC_OFS_REF0 = 4'h1;
  localparam logic [ACC_ADDR_W-1:0] ACC_OFS_STRIDE = 4'h2;

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int ACC_B_MODULE_ON = 15;
  localparam int ACC_B_IDLE_STOP = 13;
  localparam int ACC_B_PIN_DRIVE = 8;
  localparam int ACC_B_SEL_HI = 7;
  localparam int ACC_B_SEL_LO = 6;
  localparam int ACC_B_EXT_REF = 5;
  localparam int ACC_B_STATE = 3;
  localparam int ACC_B_INVERT = 1;
  localparam int ACC_B_RANGE = 0;

  // ----------------------------------------------------------------
  // reset values and read masks
  // ----------------------------------------------------------------
  localparam logic [ACC_DATA_W-1:0] ACC_RST_CTRL = 16'h0000;
  localparam logic [ACC_CODE_W-1:0] ACC_RST_CODE = 10'h000;
  localparam logic [ACC_DATA_W-1:0] ACC_ZERO = 16'h0000;

  // ----------------------------------------------------------------
  // timing: glitch filter length in instruction cycles
  // ----------------------------------------------------------------
  localparam int ACC_FILT_CYC = 2;
  localparam logic [1:0] ACC_FILT_MAX = 2'(ACC_FILT_CYC - 1);

  // ----------------------------------------------------------------
  // reference full-scale source
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ACC_RNG_INTERNAL,
    ACC_RNG_HALF_SUPPLY,
    ACC_RNG_EXTERNAL
  } acc_range_t;

  // software view of one comparator's control register
  typedef struct packed {
    logic module_on;
    logic idle_stop_all;
    logic reference_pin_drive_enable;
    logic [ACC_SEL_W-1:0] input_source_select;
    logic external_reference_select;
    logic output_invert;
    logic range_high;
  } acc_cfg_t;

  // analog steering of one comparator
  typedef struct packed {
    logic cmp_power;
    logic dac_power;
    acc_range_t dac_range;
    logic [ACC_SEL_W-1:0] plus_select;
    logic [ACC_CODE_W-1:0] reference_code;
    logic pin_drive;
  } acc_ana_t;

  // register bus request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ACC_ADDR_W-1:0] addr;
    logic [ACC_DATA_W-1:0] wdata;
  } acc_bus_t;

endpackage

/* dv/acc_analog_model.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// behavioural comparator cores and their source pins
// ----------------------------------------------------------------
module acc_analog_model
  import acc_pkg::*;
(
  // steering from the block
  input wire acc_ana_t [ACC_NUM_CMP-1:0] i_analog,
  // pin levels in reference code units
  input wire logic [ACC_NUM_PIN-1:0][ACC_CODE_W-1:0] i_pin_level,
  // raw comparator results
  output logic [ACC_NUM_CMP-1:0] o_cmp_raw
);
  // one core per comparator, low while unpowered
  always_comb
  begin
    for (int n = 0; n < ACC_NUM_CMP; n++)
    begin
      // own dac on minus, muxed pin on plus
      o_cmp_raw[n] = i_analog[n].cmp_power &&
        (i_pin_level[4 * n + i_analog[n].plus_select] > i_analog[n].reference_code);
    end
  end
endmodule

/* dv/acc_assertions.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// port checks of the comparator control block
// ----------------------------------------------------------------
module acc_assertions
  import acc_pkg::*;
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  // register port
  input wire logic i_rd,
  input wire logic [ACC_DATA_W-1:0] o_rd_data,
  // power state and raw results
  input wire logic i_sleep,
  input wire logic i_idle,
  input wire logic [ACC_NUM_CMP-1:0] i_cmp_raw,
  // block outputs
  input wire acc_ana_t [ACC_NUM_CMP-1:0] o_analog,
  input wire logic [ACC_NUM_PIN-1:0] o_pad_dig_in_off,
  input wire logic [ACC_NUM_CMP-1:0] o_pwm_cmp,
  input wire logic [ACC_NUM_CMP-1:0] o_adc_trig,
  input wire logic [ACC_NUM_CMP-1:0] o_irq_pulse,
  input wire logic [ACC_NUM_CMP-1:0] o_wake_req
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);
  // comparator 0 awake, powered, raw level unchanged
  sequence s_settled;
    (!i_sleep && !i_idle && o_analog[0].cmp_power && $stable(i_cmp_raw[0]))[*6];
  endsequence
  // one lasting raw change
  sequence s_step;
    s_settled ##1 $changed(i_cmp_raw[0]) ##1 s_settled;
  endsequence
  // a raw pulse one cycle long
  sequence s_glitch;
    s_settled ##1 $changed(i_cmp_raw[0]) ##1 $changed(i_cmp_raw[0]);
  endsequence
  a_read_idle: assert property (!$past(i_rd) |-> o_rd_data == '0)
    else $error("read data outside read cycle");
  a_trig_cause: assert property (o_adc_trig == ($past(o_pwm_cmp) & ~$past(o_pwm_cmp, 2)))
    else $error("event pulse not one cycle after rise");
  a_irq_match: assert property (o_irq_pulse == o_adc_trig)
    else $error("irq and adc pulses differ");
  a_filter_step: assert property (s_step |-> o_pwm_cmp[0] != $past(o_pwm_cmp[0], 6))
    else $error("lasting change not passed");
  a_glitch_drop: assert property (s_glitch |-> $stable(o_pwm_cmp[0])[*6])
    else $error("short pulse passed filter");
  a_wake_awake: assert property (!(i_sleep || i_idle) |-> o_wake_req == '0)
    else $error("wake request while running");
  a_power_pair: assert property (!i_idle |-> o_analog[0].cmp_power == o_analog[0].dac_power)
    else $error("dac and comparator power differ");
  a_drive_off: assert property (!o_analog[0].cmp_power |-> !o_analog[0].pin_drive)
    else $error("pin drive while off");
  a_pad_select: assert property (!i_idle |->
    o_pad_dig_in_off[3:0] == (4'(o_analog[0].cmp_power) << o_analog[0].plus_select))
    else $error("wrong pad buffer off");
  a_off_quiet: assert property ((!o_analog[0].cmp_power)[*6] |-> !o_pwm_cmp[0])
    else $error("result while off");
endmodule
bind acc_top acc_assertions u_chk (.i_clk_sys, .i_rst_b, .i_rd, .o_rd_data, .i_sleep,
  .i_idle, .i_cmp_raw, .o_analog, .o_pad_dig_in_off, .o_pwm_cmp, .o_adc_trig,
  .o_irq_pulse, .o_wake_req);

/* dv/acc_bench.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// self-checking bench of the comparator control block
// ----------------------------------------------------------------
module acc_bench;
  import acc_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_rst_b = 1'b0;
  logic [ACC_ADDR_W-1:0] i_addr = '0;
  logic [ACC_DATA_W-1:0] i_wr_data = '0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_sleep = 1'b0;
  logic i_idle = 1'b0;
  logic [ACC_NUM_PIN-1:0][ACC_CODE_W-1:0] pin_level = '0;
  logic [ACC_DATA_W-1:0] o_rd_data;
  logic [ACC_NUM_CMP-1:0] cmp_raw, o_pwm_cmp, o_adc_trig, o_irq_pulse, o_wake_req;
  acc_ana_t [ACC_NUM_CMP-1:0] o_analog;
  logic [ACC_NUM_PIN-1:0] o_pad_dig_in_off;
  logic [15:0] rng_cfg [4] = '{16'h8000, 16'h8001, 16'h8020, 16'h8021};
  acc_range_t rng_exp [4] = '{ACC_RNG_INTERNAL, ACC_RNG_HALF_SUPPLY, ACC_RNG_EXTERNAL,
    ACC_RNG_EXTERNAL};
  int err_count = 0;
  int n_tests = 0;
  // 125 MHz system clock
  always #4 i_clk_sys = ~i_clk_sys;
  acc_top DUT (.i_clk_sys, .i_rst_b, .i_addr, .i_wr_data, .i_wr, .i_rd, .o_rd_data,
    .i_sleep, .i_idle, .i_cmp_raw(cmp_raw), .o_analog, .o_pad_dig_in_off, .o_pwm_cmp,
    .o_adc_trig, .o_irq_pulse, .o_wake_req);
  acc_analog_model u_far (.i_analog(o_analog), .i_pin_level(pin_level), .o_cmp_raw(cmp_raw));
  // ----------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask
  // one-cycle register write
  task automatic bw(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_clk_sys);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wr_data <= d;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
    #1;
  endtask
  // one-cycle read, data judged in the following cycle
  task automatic br(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
    @(posedge i_clk_sys);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1;
    chk(o_rd_data & m, e);
  endtask
  task automatic give_verdict();
    $display("errors %0d tests %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_vals();
    for (int a = 0; a < 16; a++)
      br(4'(a), 16'hFFFF, 16'h0000);
    chk({15'h0, o_analog !== '0}, 16'h0000);
    chk(o_pad_dig_in_off | {12'h0, o_pwm_cmp | o_adc_trig | o_irq_pulse}, 16'h0000);
  endtask
  task automatic t_regs();
    bw(4'h0, 16'hFFFF);
    br(4'h0, 16'hFFF7, 16'hA1E3);
    chk(16'(o_analog[0].dac_range), 16'(ACC_RNG_EXTERNAL));
    chk({o_analog[0].cmp_power, o_analog[0].dac_power, o_analog[0].pin_drive,
      o_analog[0].plus_select}, 16'h001F);
    chk(o_pad_dig_in_off, 16'h0008);
    bw(4'h1, 16'hFFFF);
    br(4'h1, 16'hFFFF, 16'h03FF);
    chk(16'(o_analog[0].reference_code), 16'h03FF);
    for (int k = 0; k < 4; k++)
    begin
      bw(4'h0, rng_cfg[k]);
      chk(16'(o_analog[0].dac_range), 16'(rng_exp[k]));
    end
  endtask
  task automatic t_path();
    bw(4'h1, 16'h0100);
    bw(4'h0, 16'h8000);
    cyc(8);
    @(posedge i_clk_sys);
    pin_level[0] <= 10'h200;
    cyc(3);
    chk({15'h0, o_pwm_cmp[0]}, 16'h0000);
    cyc(1);
    chk({o_adc_trig[0], o_pwm_cmp[0]}, 16'h0001);
    cyc(1);
    chk({o_adc_trig[0], o_irq_pulse[0], o_pwm_cmp[0]}, 16'h0007);
    cyc(1);
    chk({o_adc_trig[0], o_irq_pulse[0], o_pwm_cmp[0]}, 16'h0001);
    br(4'h0, 16'hFFFF, 16'h8008);
    @(posedge i_clk_sys);
    pin_level[0] <= 10'h000;
    cyc(8);
    // single-cycle spike on the source pin
    @(posedge i_clk_sys);
    pin_level[0] <= 10'h200;
    @(posedge i_clk_sys);
    pin_level[0] <= 10'h000;
    for (int k = 0; k < 8; k++)
    begin
      cyc(1);
      chk({o_adc_trig[0], o_pwm_cmp[0]}, 16'h0000);
    end
    bw(4'h0, 16'h8002);
    cyc(6);
    chk({15'h0, o_pwm_cmp[0]}, 16'h0001);
    br(4'h0, 16'hFFFF, 16'h800A);
  endtask
  task automatic t_select();
    logic [3:0][9:0] grp;
    bw(4'h3, 16'h0100);
    for (int s = 0; s < 4; s++)
    begin
      grp = '0;
      grp[s] = 10'h200;
      @(posedge i_clk_sys);
      pin_level[7:4] <= grp;
      bw(4'h2, 16'h8000 | (16'(s) << 6));
      chk({12'h0, o_pad_dig_in_off[7:4]}, 16'h0001 << s);
      cyc(6);
      chk({15'h0, o_pwm_cmp[1]}, 16'h0001);
    end
  endtask
  task automatic t_sleep();
    @(posedge i_clk_sys);
    i_sleep <= 1'b1;
    #1;
    chk({15'h0, o_wake_req[0]}, 16'h0001);
    @(posedge i_clk_sys);
    pin_level[0] <= 10'h200;
    #1;
    chk({15'h0, o_wake_req[0]}, 16'h0000);
    @(posedge i_clk_sys);
    i_sleep <= 1'b0;
    i_idle <= 1'b1;
    pin_level[0] <= 10'h000;
    #1;
    chk({15'h0, o_wake_req[0]}, 16'h0001);
    bw(4'h2, 16'hA0C0);
    chk({14'h0, o_wake_req[1:0]}, 16'h0000);
    @(posedge i_clk_sys);
    i_idle <= 1'b0;
    cyc(8);
  endtask
  task automatic t_off();
    bw(4'h0, 16'h0100);
    chk({o_analog[0].cmp_power, o_analog[0].dac_power, o_analog[0].pin_drive}, 16'h0000);
    chk({12'h0, o_pad_dig_in_off[3:0]}, 16'h0000);
    @(posedge i_clk_sys);
    i_rst_b <= 1'b0;
    cyc(3);
    @(posedge i_clk_sys);
    i_rst_b <= 1'b1;
    br(4'h2, 16'hFFFF, 16'h0000);
  endtask
  // main sequence after 8 cycles of reset
  initial
  begin
    repeat (8) @(posedge i_clk_sys);
    i_rst_b <= 1'b1;
    t_reset_vals();
    t_regs();
    t_path();
    t_select();
    t_sleep();
    t_off();
    give_verdict();
  end
  // watchdog far beyond the expected run
  initial
  begin
    repeat (20000) @(posedge i_clk_sys);
    err_count++;
    give_verdict();
  end
endmodule
